// ---- sbt_tap.sv ----
// Purpose: Boundary-scan test access port of a synchronous burst SRAM.
// Assumes: Test clock is slow enough to be oversampled by the system clock.
// Notes: Test pins pass two flops; edges of the test clock are found here.
`timescale 1ns/100ps
module sbt_tap (
	// System clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	// Test pins from the external controller
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	// Serial data out pin, value and drive enable
	output logic tdo,
	output logic tdo_oe,
	// Memory pin ring and output control
	input wire logic [sbt_pkg::BSR_W-1:0] ring,
	output logic mem_hiz
);

	sbt_pkg::sbt_pins_t pins_a;
	sbt_pkg::sbt_pins_t pins_s;
	logic [sbt_pkg::BSR_W-1:0] ring_s;
	sbt_pkg::sbt_tap_t r_r;
	sbt_pkg::sbt_tap_t r_nxt;
	logic tck_rise;
	logic tck_fall;
	logic sel_lsb;

	// Controller state sequence
	function automatic sbt_pkg::sbt_state_t tap_next(input sbt_pkg::sbt_state_t s,
			input logic m);
		unique case (s)
			// Reset and idle
			sbt_pkg::ST_RESET: begin
				if (m) begin
					tap_next = sbt_pkg::ST_RESET;
				end else begin
					tap_next = sbt_pkg::ST_IDLE;
				end
			end
			sbt_pkg::ST_IDLE: begin
				if (m) begin
					tap_next = sbt_pkg::ST_SEL_DR;
				end else begin
					tap_next = sbt_pkg::ST_IDLE;
				end
			end
			// Data register column
			sbt_pkg::ST_SEL_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_SEL_IR;
				end else begin
					tap_next = sbt_pkg::ST_CAP_DR;
				end
			end
			sbt_pkg::ST_CAP_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT1_DR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_DR;
				end
			end
			sbt_pkg::ST_SHIFT_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT1_DR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_DR;
				end
			end
			sbt_pkg::ST_EXIT1_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_UPD_DR;
				end else begin
					tap_next = sbt_pkg::ST_PAUSE_DR;
				end
			end
			sbt_pkg::ST_PAUSE_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT2_DR;
				end else begin
					tap_next = sbt_pkg::ST_PAUSE_DR;
				end
			end
			sbt_pkg::ST_EXIT2_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_UPD_DR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_DR;
				end
			end
			sbt_pkg::ST_UPD_DR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_SEL_DR;
				end else begin
					tap_next = sbt_pkg::ST_IDLE;
				end
			end
			// Instruction register column
			sbt_pkg::ST_SEL_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_RESET;
				end else begin
					tap_next = sbt_pkg::ST_CAP_IR;
				end
			end
			sbt_pkg::ST_CAP_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT1_IR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_IR;
				end
			end
			sbt_pkg::ST_SHIFT_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT1_IR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_IR;
				end
			end
			sbt_pkg::ST_EXIT1_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_UPD_IR;
				end else begin
					tap_next = sbt_pkg::ST_PAUSE_IR;
				end
			end
			sbt_pkg::ST_PAUSE_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_EXIT2_IR;
				end else begin
					tap_next = sbt_pkg::ST_PAUSE_IR;
				end
			end
			sbt_pkg::ST_EXIT2_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_UPD_IR;
				end else begin
					tap_next = sbt_pkg::ST_SHIFT_IR;
				end
			end
			sbt_pkg::ST_UPD_IR: begin
				if (m) begin
					tap_next = sbt_pkg::ST_SEL_DR;
				end else begin
					tap_next = sbt_pkg::ST_IDLE;
				end
			end
			// Illegal codes fall back to reset
			default: begin
				tap_next = sbt_pkg::ST_RESET;
			end
		endcase
	endfunction

	// Instructions that tristate the memory outputs
	function automatic logic hiz_ins(input logic [sbt_pkg::IR_W-1:0] i);
		hiz_ins = (i == sbt_pkg::INS_EXTEST) || (i == sbt_pkg::INS_SAMPLE_Z);
	endfunction

	// Instructions that place the pin ring in the path
	function automatic logic ring_ins(input logic [sbt_pkg::IR_W-1:0] i);
		ring_ins = (i == sbt_pkg::INS_EXTEST) || (i == sbt_pkg::INS_SAMPLE)
				|| (i == sbt_pkg::INS_SAMPLE_Z);
	endfunction

	// Test pins through two flops; pulls read high until sampled
	assign pins_a.tck = tck;
	assign pins_a.tms = tms;
	assign pins_a.tdi = tdi;

	sbt_sync #(
		.WIDTH($bits(sbt_pkg::sbt_pins_t)),
		.RST_VAL(sbt_pkg::PINS_RST)
	) u_pin_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.d(pins_a),
		.q(pins_s)
	);

	// Memory pin ring through two flops
	sbt_sync #(
		.WIDTH(sbt_pkg::BSR_W),
		.RST_VAL('0)
	) u_ring_sync (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.d(ring),
		.q(ring_s)
	);

	// Test clock edges; a held-low clock never advances the port
	assign tck_rise = pins_s.tck & ~r_r.tck_d;
	assign tck_fall = ~pins_s.tck & r_r.tck_d;

	// Low bit of the one register in the serial path
	always_comb begin
		sel_lsb = r_r.bypass;
		if (r_r.state == sbt_pkg::ST_SHIFT_IR) begin
			sel_lsb = r_r.ir_sh[0];
		end else if (r_r.ir == sbt_pkg::INS_IDCODE) begin
			sel_lsb = r_r.id_sh[0];
		end else if (ring_ins(r_r.ir)) begin
			sel_lsb = r_r.bsr[0];
		end
	end

	// Next state of the whole port
	always_comb begin
		r_nxt = r_r;
		r_nxt.tck_d = pins_s.tck;
		if (tck_rise) begin
			// Register actions for the state in force at this edge
			unique case (r_r.state)
				sbt_pkg::ST_CAP_IR: begin
					r_nxt.ir_sh = sbt_pkg::IR_CAPTURE;
				end
				sbt_pkg::ST_SHIFT_IR: begin
					r_nxt.ir_sh = {pins_s.tdi, r_r.ir_sh[sbt_pkg::IR_W-1:1]};
				end
				sbt_pkg::ST_UPD_IR: begin
					r_nxt.ir = r_r.ir_sh;
					r_nxt.mem_hiz = hiz_ins(r_r.ir_sh);
					if (r_r.ir_sh == sbt_pkg::INS_BYPASS) begin
						r_nxt.bypass = sbt_pkg::BYPASS_RST;
					end
				end
				sbt_pkg::ST_CAP_DR: begin
					if (r_r.ir == sbt_pkg::INS_IDCODE) begin
						r_nxt.id_sh = sbt_pkg::ID_CODE;
					end else if (ring_ins(r_r.ir)) begin
						r_nxt.bsr = ring_s;
					end else begin
						r_nxt.bypass = sbt_pkg::BYPASS_RST;
					end
				end
				sbt_pkg::ST_SHIFT_DR: begin
					if (r_r.ir == sbt_pkg::INS_IDCODE) begin
						r_nxt.id_sh = {pins_s.tdi, r_r.id_sh[sbt_pkg::ID_W-1:1]};
					end else if (ring_ins(r_r.ir)) begin
						r_nxt.bsr = {pins_s.tdi, r_r.bsr[sbt_pkg::BSR_W-1:1]};
					end else begin
						r_nxt.bypass = pins_s.tdi;
					end
				end
				default: begin
				end
			endcase
			// Advance the controller on sampled mode select
			r_nxt.state = tap_next(r_r.state, pins_s.tms);
			// Entering reset restores the identification instruction
			if (r_nxt.state == sbt_pkg::ST_RESET) begin
				r_nxt.ir = sbt_pkg::INS_IDCODE;
				r_nxt.mem_hiz = 1'b0;
			end
		end
		// Serial output changes only on the falling test-clock edge
		if (tck_fall) begin
			r_nxt.tdo.oe = (r_r.state == sbt_pkg::ST_SHIFT_IR)
					|| (r_r.state == sbt_pkg::ST_SHIFT_DR);
			r_nxt.tdo.data = sel_lsb;
		end
	end

	// Power-up reset and state register, frozen while enable is low
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_r.state <= sbt_pkg::ST_RESET;
			r_r.ir <= sbt_pkg::INS_IDCODE;
			r_r.ir_sh <= sbt_pkg::INS_IDCODE;
			r_r.bypass <= sbt_pkg::BYPASS_RST;
			r_r.id_sh <= sbt_pkg::ID_CODE;
			r_r.bsr <= '0;
			r_r.tck_d <= 1'b0;
			r_r.mem_hiz <= 1'b0;
			r_r.tdo.data <= sbt_pkg::PIN_PULL_RST;
			r_r.tdo.oe <= 1'b0;
		end else if (ce) begin
			r_r <= r_nxt;
		end
	end

	// Outputs straight from flops
	assign tdo = r_r.tdo.data;
	assign tdo_oe = r_r.tdo.oe;
	assign mem_hiz = r_r.mem_hiz;

endmodule

// ---- sbt_pkg.sv ----
// Purpose: Shared constants and types for the SRAM boundary-scan test port.
// Assumes: Test pins are sampled by the 25 MHz system clock.
// Notes: Instruction codes other than all-zero are local encodings.
package sbt_pkg;

	// Register widths
	localparam int IR_W = 3;
	localparam int ID_W = 32;
	localparam int BSR_W = 75;

	// Instruction codes; codes not listed act as bypass
	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
	localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

	// Pattern loaded on instruction capture, low two bits are 01
	localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

	// Identification code; value is arbitrary, bit 0 marks presence
	localparam logic [ID_W-1:0] ID_CODE = 32'h0a5a_5001;

	// Reset values
	localparam logic BYPASS_RST = 1'b0;
	localparam logic PIN_PULL_RST = 1'b1;
	localparam logic [2:0] PINS_RST = 3'h3;

	// Controller states, one-hot
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SHIFT_DR = 16'h0010,
		ST_EXIT1_DR = 16'h0020,
		ST_PAUSE_DR = 16'h0040,
		ST_EXIT2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SHIFT_IR = 16'h0800,
		ST_EXIT1_IR = 16'h1000,
		ST_PAUSE_IR = 16'h2000,
		ST_EXIT2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} sbt_state_t;

	// Test pins as one group: clock, mode select, data in
	typedef struct packed {
		logic tck;
		logic tms;
		logic tdi;
	} sbt_pins_t;

	// Serial output pin pair
	typedef struct packed {
		logic data;
		logic oe;
	} sbt_tdo_t;

	// All state of the test port
	typedef struct packed {
		sbt_state_t state;
		logic [IR_W-1:0] ir;
		logic [IR_W-1:0] ir_sh;
		logic bypass;
		logic [ID_W-1:0] id_sh;
		logic [BSR_W-1:0] bsr;
		logic tck_d;
		logic mem_hiz;
		sbt_tdo_t tdo;
	} sbt_tap_t;

endpackage

// ---- sbt_sync.sv ----
// Purpose: Two-flop synchroniser for signals from outside the clock domain.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/100ps
module sbt_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	// Asynchronous input and synchronised output
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed {
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s1;
	} sbt_sync_t;

	sbt_sync_t r_r;
	sbt_sync_t r_nxt;

	// Shift one stage per clock
	always_comb begin
		r_nxt.s1 = d;
		r_nxt.s2 = r_r.s1;
	end

	// Register stages, frozen while enable is low
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			r_r.s1 <= RST_VAL;
			r_r.s2 <= RST_VAL;
		end else if (ce) begin
			r_r <= r_nxt;
		end
	end

	assign q = r_r.s2;

endmodule

// ---- sbt_tap_props.sv ----
// Purpose: Port checks for the test access port.
// Assumes: Test pins are sampled on the system clock.
// Notes: Bound to sbt_tap below.
`timescale 1ns/100ps
module sbt_tap_props (
	// Clock, reset, enable
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	// Test pins and memory tristate
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic mem_hiz
);
	logic tck_q;
	logic last_tms;
	logic [2:0] ones;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// Mode select at the last test-clock rise, run of high values
	always_ff @(posedge clock) begin
		tck_q <= tck;
		if (sys_rst) begin
			last_tms <= 1'b1;
			ones <= 3'h0;
		end else if (tck && !tck_q) begin
			last_tms <= tms;
			ones <= !tms ? 3'h0 : (ones == 3'h5 ? ones : ones + 3'h1);
		end
	end
	a_reset_quiet: assert property ($fell(sys_rst) |-> !tdo_oe && tdo && !mem_hiz)
		else $error("serial out not idle after reset");
	a_oe_after_fall: assert property ($changed(tdo_oe) |-> !$past(tck, 3) || !$past(tck, 4))
		else $error("output enable moved away from a falling test clock");
	a_tdo_after_fall: assert property (tdo_oe && $changed(tdo) |-> !$past(tck, 3) || !$past(tck, 4))
		else $error("serial out moved away from a falling test clock");
	a_hiz_on_rise: assert property ($changed(mem_hiz) |-> $past(tck, 3) && !$past(tck, 4))
		else $error("memory tristate moved away from a rising test clock");
	a_tap_reset_hiz: assert property (ones == 3'h5 |-> ##[1:6] !mem_hiz)
		else $error("five high mode edges left memory tristated");
	a_tap_reset_oe: assert property (ones == 3'h5 |-> !tdo_oe)
		else $error("serial out driven in reset state");
	a_oe_shift_entry: assert property ($rose(tdo_oe) |-> !last_tms)
		else $error("output enabled outside a shift state");
	a_ce_freeze: assert property (!ce |=> $stable({tdo, tdo_oe, mem_hiz}))
		else $error("outputs moved with clock enable low");
endmodule
bind sbt_tap sbt_tap_props u_props (.clock(clock), .sys_rst(sys_rst), .ce(ce), .tck(tck),
	.tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .mem_hiz(mem_hiz));

// ---- sbt_ctl_model.sv ----
// Purpose: Scan controller model driving the test pins.
// Assumes: Test clock period of eight system clocks.
// Notes: Test clock rests low between steps.
`timescale 1ns/100ps
module sbt_ctl_model (
	// Pacing clock
	input wire logic clock,
	// Test pins
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo_w
);
	// Idle levels, pulled-up lines high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// One period: drive after the fall, rise, sample before next fall
	task automatic step(input logic m, input logic d, output logic q);
		@(negedge clock);
		tms = m;
		tdi = d;
		repeat (4) @(negedge clock);
		tck = 1'b1;
		repeat (3) @(negedge clock);
		q = tdo_w;
		tck = 1'b0;
	endtask
endmodule

// ---- sbt_tap_bench.sv ----
// Purpose: Self-checking bench for the test access port.
// Assumes: Controller model paces the test clock.
// Notes: Serial out wire floats when not driven.
`timescale 1ns/100ps
module sbt_tap_bench;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic tck, tms, tdi, tdo, tdo_oe, mem_hiz;
	logic [74:0] ring = 75'h4_c3a5_9610_f0e1_d2b7;
	wire logic tdo_w;
	int n_errors = 0;
	int n_tests = 0;
	assign tdo_w = tdo_oe ? tdo : 1'bz;
	always #20 clock = ~clock;
	sbt_tap DUT (.clock(clock), .sys_rst(sys_rst), .ce(ce), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring(ring), .mem_hiz(mem_hiz));
	sbt_ctl_model ctl (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w));
	task automatic conclude();
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
		n_tests++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// From idle: one scan of n bits, then update and back to idle
	task automatic scan(input logic ir, input int n, input logic [79:0] din,
		output logic [79:0] o);
		logic q;
		o = '0;
		ctl.step(1'b1, 1'b1, q);
		if (ir)
			ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			ctl.step(i == n - 1, din[i], q);
			o[i] = q;
		end
		ctl.step(1'b1, 1'b1, q);
		ctl.step(1'b0, 1'b1, q);
	endtask
	task automatic t_id();
		logic [79:0] o;
		logic q;
		chk("quiet", 80'h2, 80'({tdo_oe, tdo, mem_hiz}));
		ctl.step(1'b0, 1'b1, q);
		scan(1'b0, 33, 80'hffff_fffe, o);
		chk("idcode", {48'h0, sbt_pkg::ID_CODE}, o);
	endtask
	task automatic t_byp();
		logic [79:0] o;
		scan(1'b1, 3, 80'(sbt_pkg::INS_BYPASS), o);
		chk("ir_capture", 80'(sbt_pkg::IR_CAPTURE), o);
		scan(1'b0, 8, 80'h35, o);
		chk("bypass", 80'h6a, o);
	endtask
	task automatic t_codes();
		logic [79:0] o;
		logic [79:0] e;
		logic [2:0] k;
		logic rg;
		for (int c = 0; c < 8; c++) begin
			k = c[2:0];
			rg = k == sbt_pkg::INS_EXTEST || k == sbt_pkg::INS_SAMPLE_Z;
			scan(1'b1, 3, 80'(k), o);
			chk("mem_hiz", 80'(rg), 80'(mem_hiz));
			e = ~80'h1;
			if (k == sbt_pkg::INS_IDCODE)
				e = {{48{1'b1}}, sbt_pkg::ID_CODE};
			if (rg || k == sbt_pkg::INS_SAMPLE)
				e = {5'h1f, ring};
			scan(1'b0, 80, ~80'h0, o);
			chk("dr_path", e, o);
		end
	endtask
	task automatic t_rst5();
		logic [79:0] o;
		logic q;
		scan(1'b1, 3, 80'(sbt_pkg::INS_EXTEST), o);
		ctl.step(1'b1, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		ctl.step(1'b0, 1'b0, q);
		repeat (5) ctl.step(1'b1, 1'b0, q);
		repeat (3) @(negedge clock);
		chk("hiz_reset", 80'h0, 80'(mem_hiz));
		ctl.step(1'b0, 1'b1, q);
		scan(1'b0, 32, 80'h0, o);
		chk("ir_reset", {48'h0, sbt_pkg::ID_CODE}, o);
	endtask
	initial begin
		repeat (8) @(negedge clock);
		sys_rst = 1'b0;
		ce = 1'b0;
		repeat (3) @(negedge clock);
		ce = 1'b1;
		repeat (4) @(negedge clock);
		t_id();
		t_byp();
		t_codes();
		t_rst5();
		conclude();
	end
	// Watchdog well beyond the expected run
	initial begin
		#1000000;
		n_errors++;
		conclude();
	end
endmodule
